// ==== aqs_pkg.sv ====
// How it works
// RULE1 - step 1 joins the auxiliary converter sequence only while step1_include_bit is 1, else it is skipped.
// RULE2 - step1_gain_code drives the converter gain during step 1: 00 is gain 1, 01 is gain 2, 10 and 11 are gain 4.
// RULE3 - during step 1 step1_negative_select connects analog_ground_ref when 0 and external_input_7 when 1.
// RULE4 - in step 1 a step1_positive_select code n from 0000 to 0111 routes external input n to the positive input.
// RULE5 - codes 1000 and up pick the negative input internally and ignore step1_negative_select.
// RULE6 - code 1000 picks the temperature sensor, 1001 an internal short to ground with inputs open, 1010 the test DAC.
// RULE7 - codes 1011 to 1111 pick the scaled supply monitors, with 1111 being digital_power_input divided by 103.
// RULE8 - aux_sequence_step1_config sits at address 0x91 and resets to 0x0001.
// RULE9 - reserved bits 12 down to 5 read as zero and ignore written values.
package aqs_pkg;

  localparam logic [7:0] ADDR_STEP1_CFG = 8'h91;
  localparam logic [7:0] ADDR_STATUS = 8'hF0;
  localparam logic [7:0] ADDR_TAKE_COUNT = 8'hF1;

  localparam logic [15:0] CFG_RESET = 16'h0001;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  localparam int EN_BIT = 15;
  localparam int GAIN_HI = 14;
  localparam int GAIN_LO = 13;
  localparam int NEG_BIT = 4;
  localparam int POS_HI = 3;
  localparam int POS_LO = 0;
  localparam int STAT_APPLY_BIT = 0;
  localparam int STAT_AUTONEG_BIT = 1;
  localparam int STAT_PENDING_BIT = 2;

  localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
  localparam logic [1:0] GAIN_CODE_X2 = 2'h1;

  localparam logic [3:0] POS_TEMP = 4'h8;
  localparam logic [3:0] POS_SHORT = 4'h9;
  localparam logic [3:0] POS_TEST_DAC = 4'hA;
  localparam logic [3:0] POS_SUPPLY_FIRST = 4'hB;

  typedef struct packed {
    logic enable;
    logic [1:0] gainCode;
    logic negSel;
    logic [3:0] posSel;
  } aqs_cfg_t;

  // gainSel is one-hot: bit0 gain 1, bit1 gain 2, bit2 gain 4
  // supplyMon index 0 is code 1011, index 4 is code 1111 (digital power / 103)
  typedef struct packed {
    logic [2:0] gainSel;
    logic negGround;
    logic negExt7;
    logic negAuto;
    logic [7:0] extIn;
    logic tempSensor;
    logic shortGnd;
    logic testDac;
    logic [4:0] supplyMon;
  } aqs_route_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_APPLY = 2'h2
  } aqs_state_t;

endpackage

// ==== aqs_route_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
module aqs_route_decode
  import aqs_pkg::*;
(
  input wire aqs_cfg_t cfg,
  output var aqs_route_t route
);

  always_comb
  begin
    route = '0;
    case (cfg.gainCode)
      GAIN_CODE_X1: route.gainSel = 3'h1; // see RULE2
      GAIN_CODE_X2: route.gainSel = 3'h2; // see RULE2
      default: route.gainSel = 3'h4; // see RULE2
    endcase
    if (!cfg.posSel[3])
    begin
      route.extIn[cfg.posSel[2:0]] = 1'b1; // see RULE4
      route.negGround = ~cfg.negSel; // see RULE3
      route.negExt7 = cfg.negSel; // see RULE3
    end
    else
    begin
      // internal sources pick their own return, the select bit is dropped
      route.negAuto = 1'b1; // see RULE5
      if (cfg.posSel == POS_TEMP)
      begin
        route.tempSensor = 1'b1; // see RULE6
      end
      else if (cfg.posSel == POS_SHORT)
      begin
        route.shortGnd = 1'b1; // see RULE6
      end
      else if (cfg.posSel == POS_TEST_DAC)
      begin
        route.testDac = 1'b1; // see RULE6
      end
      else
      begin
        route.supplyMon[3'(cfg.posSel - POS_SUPPLY_FIRST)] = 1'b1; // see RULE7
      end
    end
  end

endmodule
`default_nettype wire

// ==== aqs_step1_config.sv ====
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module aqs_step1_config
  import aqs_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  input wire logic seqStepReq,
  input wire logic seqStepDone,
  output logic stepTake,
  output logic stepSkip,
  output logic frontEndValid,
  output logic [2:0] gainSel,
  output logic negGround,
  output logic negExt7,
  output logic negAuto,
  output logic [7:0] extIn,
  output logic tempSensor,
  output logic shortGnd,
  output logic testDac,
  output logic [4:0] supplyMon,
  output logic step1Include,
  output logic [1:0] step1GainCode,
  output logic step1NegativeSelect,
  output logic [3:0] step1PositiveSelect
);

  typedef struct packed {
    aqs_cfg_t cfg;
    aqs_cfg_t snap;
    aqs_route_t route;
    aqs_state_t state;
    logic pending;
    logic [15:0] takeCount;
    logic [15:0] rdata;
  } aqs_core_t;

  aqs_core_t core_reg;
  aqs_core_t core_next;
  aqs_route_t liveRoute;
  aqs_cfg_t wordCfg;
  logic cfgWrite;
  logic countWrite;

  function automatic aqs_cfg_t cfg_from_word(input logic [15:0] w);
    aqs_cfg_t c;
    c.enable = w[EN_BIT];
    c.gainCode = w[GAIN_HI:GAIN_LO];
    c.negSel = w[NEG_BIT];
    c.posSel = w[POS_HI:POS_LO];
    return c;
  endfunction

  // reserved positions are simply never stored, so they read back as zero
  function automatic logic [15:0] word_from_cfg(input aqs_cfg_t c);
    logic [15:0] w;
    w = 16'h0000; // see RULE9
    w[EN_BIT] = c.enable;
    w[GAIN_HI:GAIN_LO] = c.gainCode;
    w[NEG_BIT] = c.negSel;
    w[POS_HI:POS_LO] = c.posSel;
    return w;
  endfunction

  function automatic aqs_core_t core_reset();
    aqs_core_t r;
    r = '0;
    r.cfg = cfg_from_word(CFG_RESET); // see RULE8
    r.snap = cfg_from_word(CFG_RESET);
    r.state = ST_IDLE;
    r.takeCount = COUNT_RESET;
    return r;
  endfunction

  assign wordCfg = cfg_from_word(regWdata);
  assign cfgWrite = regWrite && (regAddr == ADDR_STEP1_CFG); // see RULE8
  assign countWrite = regWrite && (regAddr == ADDR_TAKE_COUNT);

  // the front end is fed from a snapshot taken when the step starts, so a
  // write landing mid-conversion cannot switch the mux under a live sample
  aqs_route_decode u_decode (
    .cfg(core_reg.snap),
    .route(liveRoute)
  );

  // include decision is answered in the same cycle as the request
  assign stepTake = seqStepReq && core_reg.cfg.enable && (core_reg.state == ST_IDLE); // see RULE1
  assign stepSkip = seqStepReq && !core_reg.cfg.enable && (core_reg.state == ST_IDLE); // see RULE1

  always_comb
  begin
    core_next = core_reg;
    core_next.rdata = 16'h0000;

    if (cfgWrite)
    begin
      core_next.cfg = wordCfg; // see RULE9
    end

    case (core_reg.state)
      ST_IDLE:
      begin
        core_next.route = '0;
        if (stepTake)
        begin
          core_next.snap = cfgWrite ? wordCfg : core_reg.cfg;
          core_next.state = ST_APPLY;
        end
      end
      ST_APPLY:
      begin
        core_next.route = liveRoute; // see RULE2
        if (seqStepDone)
        begin
          core_next.state = ST_IDLE;
          core_next.route = '0;
        end
      end
      default:
      begin
        core_next.state = ST_IDLE;
        core_next.route = '0;
      end
    endcase

    // pending marks a write that will only reach the front end next step;
    // a new write in the closing cycle keeps it set
    if (cfgWrite && (core_reg.state == ST_APPLY))
    begin
      core_next.pending = 1'b1;
    end
    else if (core_reg.state == ST_IDLE)
    begin
      core_next.pending = 1'b0;
    end

    if (countWrite)
    begin
      core_next.takeCount = COUNT_RESET;
    end
    else if (stepTake)
    begin
      core_next.takeCount = core_reg.takeCount + 16'h0001;
    end

    if (regRead)
    begin
      case (regAddr)
        ADDR_STEP1_CFG:
        begin
          core_next.rdata = word_from_cfg(core_reg.cfg); // see RULE9
        end
        ADDR_STATUS:
        begin
          core_next.rdata[STAT_APPLY_BIT] = (core_reg.state == ST_APPLY);
          core_next.rdata[STAT_AUTONEG_BIT] = core_reg.route.negAuto;
          core_next.rdata[STAT_PENDING_BIT] = core_reg.pending;
        end
        ADDR_TAKE_COUNT:
        begin
          core_next.rdata = core_reg.takeCount;
        end
        default:
        begin
          core_next.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      core_reg <= core_reset();
    end
    else
    begin
      core_reg <= core_next;
    end
  end

  assign regRdata = core_reg.rdata;
  assign frontEndValid = (core_reg.state == ST_APPLY);
  assign gainSel = core_reg.route.gainSel;
  assign negGround = core_reg.route.negGround;
  assign negExt7 = core_reg.route.negExt7;
  assign negAuto = core_reg.route.negAuto;
  assign extIn = core_reg.route.extIn;
  assign tempSensor = core_reg.route.tempSensor;
  assign shortGnd = core_reg.route.shortGnd;
  assign testDac = core_reg.route.testDac;
  assign supplyMon = core_reg.route.supplyMon;
  assign step1Include = core_reg.cfg.enable;
  assign step1GainCode = core_reg.cfg.gainCode;
  assign step1NegativeSelect = core_reg.cfg.negSel;
  assign step1PositiveSelect = core_reg.cfg.posSel;

endmodule
`default_nettype wire

// ==== aqs_step1_config_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module aqs_step1_config_monitor
  import aqs_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [15:0] regRdata,
  input wire logic seqStepReq,
  input wire logic seqStepDone,
  input wire logic stepTake,
  input wire logic stepSkip,
  input wire logic frontEndValid,
  input wire logic [7:0] extIn,
  input wire logic step1Include,
  input wire logic [1:0] step1GainCode,
  input wire logic step1NegativeSelect,
  input wire logic [3:0] step1PositiveSelect
);
  wire [15:0] cfgNow = {step1Include, step1GainCode, 8'h00, step1NegativeSelect, step1PositiveSelect};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_take;
    seqStepReq && !frontEndValid |-> stepTake == step1Include && stepSkip == !step1Include;
  endproperty
  a_take: assert property (p_take) else $error("take");
  property p_skip;
    stepSkip |=> !frontEndValid;
  endproperty
  a_skip: assert property (p_skip) else $error("skip");
  property p_apply;
    stepTake |=> frontEndValid;
  endproperty
  a_apply: assert property (p_apply) else $error("apply");
  property p_hold;
    frontEndValid && !seqStepDone |=> frontEndValid;
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_done;
    frontEndValid && seqStepDone |=> !frontEndValid && extIn == 8'h00;
  endproperty
  a_done: assert property (p_done) else $error("done");
  // the snapshot sees the field value one cycle after the take, so a same-cycle write counts
  property p_ext;
    stepTake ##1 !seqStepDone |=> extIn == ($past(step1PositiveSelect[3]) ? 8'h00 :
      8'h01 << $past(step1PositiveSelect[2:0]));
  endproperty
  a_ext: assert property (p_ext) else $error("ext");
  property p_rd;
    regRead && regAddr == ADDR_STEP1_CFG |=> regRdata == cfgNow;
  endproperty
  a_rd: assert property (p_rd) else $error("read");
  property p_rsv;
    regRead && regAddr == ADDR_STEP1_CFG |=> regRdata[12:5] == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  c_take: cover property (stepTake);
  c_skip: cover property (stepSkip);
  c_auto: cover property (stepTake && step1PositiveSelect[3]);
endmodule
bind aqs_step1_config aqs_step1_config_monitor mon (.clk(clk), .nrst(nrst), .regAddr(regAddr),
  .regRead(regRead), .regRdata(regRdata), .seqStepReq(seqStepReq), .seqStepDone(seqStepDone),
  .stepTake(stepTake), .stepSkip(stepSkip), .frontEndValid(frontEndValid), .extIn(extIn),
  .step1Include(step1Include), .step1GainCode(step1GainCode),
  .step1NegativeSelect(step1NegativeSelect), .step1PositiveSelect(step1PositiveSelect));
`default_nettype wire

// ==== tb_aqs_step1_config.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_aqs_step1_config import aqs_pkg::*;;
  logic clk, nrst, regWrite, regRead, seqStepReq, seqStepDone;
  logic [7:0] regAddr;
  logic [15:0] regWdata;
  wire [15:0] regRdata;
  // take, skip, applied, then route as gain, neg, ext, internal, supply
  wire [24:0] obs;
  int errCount = 0;
  int checksDone = 0;
  aqs_step1_config dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .seqStepReq(seqStepReq), .seqStepDone(seqStepDone),
    .stepTake(obs[24]), .stepSkip(obs[23]), .frontEndValid(obs[22]), .gainSel(obs[21:19]),
    .negGround(obs[18]), .negExt7(obs[17]), .negAuto(obs[16]), .extIn(obs[15:8]), .tempSensor(obs[7]),
    .shortGnd(obs[6]), .testDac(obs[5]), .supplyMon(obs[4:0]), .step1Include(), .step1GainCode(),
    .step1NegativeSelect(), .step1PositiveSelect());
  function automatic logic [21:0] expRoute(input logic [15:0] c);
    logic [21:0] r;
    r = 22'h0;
    r[21:19] = (c[14:13] == 2'h0) ? 3'h1 : ((c[14:13] == 2'h1) ? 3'h2 : 3'h4);
    if (!c[3])
    begin
      r[18:17] = c[4] ? 2'h1 : 2'h2;
      r[15:8] = 8'h01 << c[2:0];
    end
    else
    begin
      r[16] = 1'h1;
      r[7:5] = (c[2:0] < 3'h3) ? 3'h4 >> c[1:0] : 3'h0;
      r[4:0] = (c[2:0] < 3'h3) ? 5'h00 : 5'h01 << (c[2:0] - 3'h3);
    end
    return r;
  endfunction
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      errCount++;
      $display("Error at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk({9'h0, regRdata}, {9'h0, exp});
    // read data stand for one cycle only, then fall back to zero
    @(negedge clk);
    chk({9'h0, regRdata}, 25'h0);
  endtask
  // done is raised in the first routed cycle, the shortest step the sequencer may run
  task automatic st(input logic [15:0] c);
    wr(ADDR_STEP1_CFG, c);
    seqStepReq <= 1'b1;
    @(negedge clk);
    chk(obs, {c[15], !c[15], 23'h0});
    @(posedge clk);
    seqStepReq <= 1'b0;
    @(posedge clk);
    seqStepDone <= 1'b1;
    @(negedge clk);
    chk(obs, c[15] ? {3'h1, expRoute(c)} : 25'h0);
    @(posedge clk);
    seqStepDone <= 1'b0;
    @(negedge clk);
    chk(obs, 25'h0);
  endtask
  task automatic wrapUp;
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    errCount++;
    wrapUp;
  end
  initial
  begin
    {nrst, regWrite, regRead, seqStepReq, seqStepDone, regAddr, regWdata} = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_STEP1_CFG, 16'h0001);
    wr(ADDR_STEP1_CFG, 16'hFFFF);
    rd(ADDR_STEP1_CFG, 16'hE01F);
    rd(8'h00, 16'h0000);
    $display("register test done");
    st(16'h0013);
    for (int p = 0; p < 16; p++)
    begin
      st({1'b1, p[1:0], 8'h00, p[0], p[3:0]});
    end
    rd(ADDR_TAKE_COUNT, 16'h0010);
    $display("sequence test done");
    wr(ADDR_TAKE_COUNT, 16'hFFFF);
    rd(ADDR_TAKE_COUNT, 16'h0000);
    rd(ADDR_STATUS, 16'h0000);
    // a second reset in mid-run must bring back the reset word over the written one
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_STEP1_CFG, 16'h0001);
    rd(ADDR_TAKE_COUNT, 16'h0000);
    $display("reset test done");
    wrapUp;
  end
endmodule
`default_nettype wire
